/* brl_defs.svh */
`ifndef BRL_DEFS_SVH
`define BRL_DEFS_SVH

// Rail counts: rails 0..2 ramp under voltage scaling, the rest step.
`define BRL_NRAIL 5
`define BRL_NDVS 3
`define BRL_NPIN 3

// Device register offsets on the link bus.
`define BRL_A_MASK_A 8'h00
`define BRL_A_MASK_B 8'h01
`define BRL_A_PHASE 8'h02
`define BRL_A_STATUS 8'h03
`define BRL_A_MAP_BASE 8'h04
`define BRL_A_PRI_BASE 8'h10
`define BRL_A_ALT_BASE 8'h18
`define BRL_A_CTL_BASE 8'h20

// Reset values; a set bit in the first mask removes that rail, the second mask holds mode fields.
`define BRL_MASK_A_RST 5'h1e
`define BRL_MASK_B_RST 8'h04

// Field positions.
`define BRL_MB_CUR_ONLY 0
`define BRL_MB_CONV_EN 1
`define BRL_MB_CONV_MASK 2
`define BRL_MB_INVERT 3
`define BRL_ALT_CMD_BIT 7
`define BRL_PRI_RANGE_BIT 7
`define BRL_CTL_PIN_EN_BIT 0

// Ramp timing: slew in uV per us, step sizes in uV.
`define BRL_CLK_NS 10
`define BRL_SLEW_UV_PER_US 2500
`define BRL_STEP0_UV 10000
`define BRL_STEP1_UV 20000
`define BRL_STEP0_CYC ((`BRL_STEP0_UV*1000/`BRL_SLEW_UV_PER_US)/`BRL_CLK_NS)
`define BRL_STEP1_CYC ((`BRL_STEP1_UV*1000/`BRL_SLEW_UV_PER_US)/`BRL_CLK_NS)

// Voltage code decode in mV.
`define BRL_R0_BASE_MV 13'h1f4
`define BRL_R0_STEP_MV 13'h00a
`define BRL_R0_MAX_MV 13'h672
`define BRL_R1_BASE_MV 13'h3e8
`define BRL_R1_STEP_MV 13'h014
`define BRL_R1_MAX_MV 13'hce4

// Host register byte offsets and AXI responses.
`define BRL_H_CMD 4'h0
`define BRL_H_STAT 4'h4
`define BRL_H_PINS 4'h8
`define BRL_RESP_OKAY 2'h0
`define BRL_RESP_SLVERR 2'h2

`endif

/* brl_pkg.sv */
`default_nettype none
package brl_pkg;

  // Host side link sequencer.
  typedef enum logic [1:0] {
    BRL_LINK_IDLE = 2'b01,
    BRL_LINK_WAIT = 2'b10
  } brl_link_state_type;

  // Paired rail phase handling.
  typedef enum logic [1:0] {
    BRL_PH_AUTO   = 2'h0,
    BRL_PH_MULTI  = 2'h1,
    BRL_PH_SINGLE = 2'h2
  } brl_phase_type;

endpackage : brl_pkg
`default_nettype wire

/* brl_if.sv */
`default_nettype none
interface brl_if;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       reg_ack;
  logic [2:0] level_pin;

  modport dev (
    input  reg_addr,
    input  reg_wdata,
    input  reg_wr,
    input  reg_rd,
    input  level_pin,
    output reg_rdata,
    output reg_ack
  );

  modport host (
    output reg_addr,
    output reg_wdata,
    output reg_wr,
    output reg_rd,
    output level_pin,
    input  reg_rdata,
    input  reg_ack
  );
endinterface : brl_if
`default_nettype wire

/* brl_device.sv */
`include "brl_defs.svh"
`default_nettype none

module brl_device
  import brl_pkg::*;
(
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_b_i,
  brl_if.dev                             bus,
  input  wire logic [`BRL_NRAIL-1:0]     win_ok_i,
  input  wire logic [`BRL_NRAIL-1:0]     cur_ok_i,
  input  wire logic                      conv_cur_ok_i,
  input  wire logic                      dual_phase_i,
  output logic                           rail_ok_o,
  output logic [`BRL_NRAIL*8-1:0]        level_code_o,
  output logic [`BRL_NRAIL*12-1:0]       level_mv_o,
  output logic [`BRL_NRAIL-1:0]          rail_ramping_o,
  output logic [1:0]                     phase_mode_o
);

  localparam int SW = 2 * `BRL_NRAIL + 2 + `BRL_NPIN;

  // Decode a voltage code into millivolts, saturating at the range top.
  function automatic logic [11:0] code_to_mv(input logic       rng,
                                             input logic [6:0] c);
    logic [12:0] v;
    v = 13'h000;
    if (c != 7'h00)
    begin
      if (rng)
      begin
        v = `BRL_R1_BASE_MV + 13'(c - 7'h01) * `BRL_R1_STEP_MV;
        if (v > `BRL_R1_MAX_MV)
          v = `BRL_R1_MAX_MV;
      end
      else
      begin
        v = `BRL_R0_BASE_MV + 13'(c - 7'h01) * `BRL_R0_STEP_MV;
        if (v > `BRL_R0_MAX_MV)
          v = `BRL_R0_MAX_MV;
      end
    end
    return v[11:0];
  endfunction : code_to_mv

  logic [SW-1:0]           sync1_r;
  logic [SW-1:0]           sync2_r;
  logic [`BRL_NRAIL-1:0]   win_s;
  logic [`BRL_NRAIL-1:0]   cur_s;
  logic                    conv_s;
  logic                    dual_s;
  logic [`BRL_NPIN-1:0]    pin_s;

  // Comparator results, the strap and the level pins are all asynchronous.
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= {dual_phase_i, conv_cur_ok_i, cur_ok_i, win_ok_i,
                  bus.level_pin};
      sync2_r <= sync1_r;
    end
  end

  assign pin_s  = sync2_r[`BRL_NPIN-1:0];
  assign win_s  = sync2_r[`BRL_NPIN +: `BRL_NRAIL];
  assign cur_s  = sync2_r[`BRL_NPIN+`BRL_NRAIL +: `BRL_NRAIL];
  assign conv_s = sync2_r[SW-2];
  assign dual_s = sync2_r[SW-1];

  logic [`BRL_NRAIL-1:0]  mask_a_r, mask_a_nxt;
  logic [7:0]             mask_b_r, mask_b_nxt;
  logic [1:0]             phase_r, phase_nxt;
  logic [`BRL_NRAIL-1:0]  map_r [`BRL_NPIN];
  logic [`BRL_NRAIL-1:0]  map_nxt [`BRL_NPIN];
  logic [7:0]             pri_r [`BRL_NRAIL];
  logic [7:0]             pri_nxt [`BRL_NRAIL];
  logic [7:0]             alt_r [`BRL_NRAIL];
  logic [7:0]             alt_nxt [`BRL_NRAIL];
  logic                   pen_r [`BRL_NRAIL];
  logic                   pen_nxt [`BRL_NRAIL];
  logic [7:0]             rdata_r, rdata_nxt;
  logic                   ack_r, ack_nxt;
  logic                   rail_ok_r, rail_ok_nxt;
  logic [1:0]             phase_o_r, phase_o_nxt;
  logic [`BRL_NRAIL-1:0]  ramp_r;

  // Register file: writes and reads both answer with ack one cycle later.
  always_comb
  begin
    mask_a_nxt = mask_a_r;
    mask_b_nxt = mask_b_r;
    phase_nxt  = phase_r;
    map_nxt    = map_r;
    pri_nxt    = pri_r;
    alt_nxt    = alt_r;
    pen_nxt    = pen_r;
    rdata_nxt  = rdata_r;
    ack_nxt    = bus.reg_wr | bus.reg_rd;
    if (bus.reg_wr)
    begin
      if (bus.reg_addr == `BRL_A_MASK_A)
        mask_a_nxt = bus.reg_wdata[`BRL_NRAIL-1:0];
      if (bus.reg_addr == `BRL_A_MASK_B)
        mask_b_nxt = bus.reg_wdata;
      if (bus.reg_addr == `BRL_A_PHASE)
        phase_nxt = bus.reg_wdata[1:0];
      for (int k = 0; k < `BRL_NPIN; k++)
        if (bus.reg_addr == `BRL_A_MAP_BASE + 8'(k))
          map_nxt[k] = bus.reg_wdata[`BRL_NRAIL-1:0];
      for (int i = 0; i < `BRL_NRAIL; i++)
      begin
        if (bus.reg_addr == `BRL_A_PRI_BASE + 8'(i))
          pri_nxt[i] = bus.reg_wdata;
        if (bus.reg_addr == `BRL_A_ALT_BASE + 8'(i))
          alt_nxt[i] = bus.reg_wdata;
        if (bus.reg_addr == `BRL_A_CTL_BASE + 8'(i))
          pen_nxt[i] = bus.reg_wdata[`BRL_CTL_PIN_EN_BIT];
      end
    end
    if (bus.reg_rd)
    begin
      rdata_nxt = 8'h00;
      if (bus.reg_addr == `BRL_A_MASK_A)
        rdata_nxt = 8'(mask_a_r);
      if (bus.reg_addr == `BRL_A_MASK_B)
        rdata_nxt = mask_b_r;
      if (bus.reg_addr == `BRL_A_PHASE)
        rdata_nxt = {6'h00, phase_r};
      if (bus.reg_addr == `BRL_A_STATUS)
        rdata_nxt = {dual_s, 1'b0, ramp_r, rail_ok_r};
      for (int k = 0; k < `BRL_NPIN; k++)
        if (bus.reg_addr == `BRL_A_MAP_BASE + 8'(k))
          rdata_nxt = 8'(map_r[k]);
      for (int i = 0; i < `BRL_NRAIL; i++)
      begin
        if (bus.reg_addr == `BRL_A_PRI_BASE + 8'(i))
          rdata_nxt = pri_r[i];
        if (bus.reg_addr == `BRL_A_ALT_BASE + 8'(i))
          rdata_nxt = alt_r[i];
        if (bus.reg_addr == `BRL_A_CTL_BASE + 8'(i))
          rdata_nxt = {7'h00, pen_r[i]};
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mask_a_r <= `BRL_MASK_A_RST;
      mask_b_r <= `BRL_MASK_B_RST;
      phase_r  <= BRL_PH_AUTO;
      map_r    <= '{default: '0};
      pri_r    <= '{default: '0};
      alt_r    <= '{default: '0};
      pen_r    <= '{default: 1'b0};
      rdata_r  <= 8'h00;
      ack_r    <= 1'b0;
    end
    else
    begin
      mask_a_r <= mask_a_nxt;
      mask_b_r <= mask_b_nxt;
      phase_r  <= phase_nxt;
      map_r    <= map_nxt;
      pri_r    <= pri_nxt;
      alt_r    <= alt_nxt;
      pen_r    <= pen_nxt;
      rdata_r  <= rdata_nxt;
      ack_r    <= ack_nxt;
    end
  end

  assign bus.reg_rdata = rdata_r;
  assign bus.reg_ack   = ack_r;

  // Per rail target selection and ramp.
  for (genvar g = 0; g < `BRL_NRAIL; g++)
  begin : g_rail
    logic [6:0]  code_r, code_nxt;
    logic        rng_r, rng_nxt;
    logic [9:0]  tmr_r, tmr_nxt;
    logic        rmp_r, rmp_nxt;
    logic [11:0] mv_r;
    logic        pin_act;
    logic        use_alt;
    logic [6:0]  tgt;
    logic [9:0]  step;

    // A ramp only walks between two live codes; off and on are immediate.
    always_comb
    begin
      pin_act = 1'b0;
      for (int k = 0; k < `BRL_NPIN; k++)
        pin_act = pin_act | (map_r[k][g] & pin_s[k]);
      if (pen_r[g])
        use_alt = ~pin_act;
      else
        use_alt = alt_r[g][`BRL_ALT_CMD_BIT];
      tgt = use_alt ? alt_r[g][6:0] : pri_r[g][6:0];
      if (g == 1 && dual_s)
        tgt = 7'h00;
      rng_nxt  = pri_r[g][`BRL_PRI_RANGE_BIT];
      step     = rng_r ? 10'(`BRL_STEP1_CYC - 1) : 10'(`BRL_STEP0_CYC - 1);
      code_nxt = code_r;
      tmr_nxt  = tmr_r;
      rmp_nxt  = 1'b0;
      if (g < `BRL_NDVS && tgt != 7'h00 && code_r != 7'h00 && tgt != code_r)
      begin
        rmp_nxt = 1'b1;
        if (tmr_r == 10'h000)
        begin
          code_nxt = (tgt > code_r) ? code_r + 7'h01 : code_r - 7'h01;
          tmr_nxt  = step;
        end
        else
          tmr_nxt = tmr_r - 10'h001;
      end
      else
      begin
        code_nxt = tgt;
        tmr_nxt  = step;
      end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        code_r    <= 7'h00;
        rng_r     <= 1'b0;
        tmr_r     <= 10'h000;
        rmp_r     <= 1'b0;
        mv_r      <= 12'h000;
      end
      else
      begin
        code_r    <= code_nxt;
        rng_r     <= rng_nxt;
        tmr_r     <= tmr_nxt;
        rmp_r     <= rmp_nxt;
        mv_r      <= code_to_mv(rng_r, code_r);
      end
    end

    assign level_code_o[g*8 +: 8]  = {rng_r, code_r};
    assign level_mv_o[g*12 +: 12]  = mv_r;
    // Each rail owns its ramp flop; the vector only gathers them.
    assign ramp_r[g]               = rmp_r;
  end

  // Rail-ok combine; the window check drops out while a rail ramps.
  always_comb
  begin
    logic [`BRL_NRAIL-1:0] eff_mask;
    logic [`BRL_NRAIL-1:0] fail;
    logic                  conv_fail;
    eff_mask = mask_a_r;
    if (dual_s)
      eff_mask[1] = 1'b1;
    for (int i = 0; i < `BRL_NRAIL; i++)
      fail[i] = ~eff_mask[i] & (~cur_s[i] |
                (~mask_b_r[`BRL_MB_CUR_ONLY] & ~ramp_r[i] & ~win_s[i]));
    conv_fail = mask_b_r[`BRL_MB_CONV_EN] & ~mask_b_r[`BRL_MB_CONV_MASK] &
                ~conv_s;
    // Good reads high unless the polarity bit inverts it.
    rail_ok_nxt = ~(|fail | conv_fail) ^ mask_b_r[`BRL_MB_INVERT];
    phase_o_nxt = dual_s ? phase_r : BRL_PH_AUTO;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rail_ok_r <= 1'b0;
      phase_o_r <= BRL_PH_AUTO;
    end
    else
    begin
      rail_ok_r <= rail_ok_nxt;
      phase_o_r <= phase_o_nxt;
    end
  end

  assign rail_ok_o      = rail_ok_r;
  assign rail_ramping_o = ramp_r;
  assign phase_mode_o   = phase_o_r;

endmodule : brl_device
`default_nettype wire

/* brl_host.sv */
`include "brl_defs.svh"
`default_nettype none

module brl_host
  import brl_pkg::*;
#(
  parameter int ADDR_W = 4
)
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_b_i,
  brl_if.host                    bus,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i
);

  // Word decode shared by both channels: 0 cmd, 1 status, 2 pins, 3 none.
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [1:0] s;
    s = 2'h3;
    if (a[3:2] == `BRL_H_CMD >> 2)
      s = 2'h0;
    if (a[3:2] == `BRL_H_STAT >> 2)
      s = 2'h1;
    if (a[3:2] == `BRL_H_PINS >> 2)
      s = 2'h2;
    return s;
  endfunction : reg_sel

  brl_link_state_type st_r, st_nxt;
  logic              aw_h_r, aw_h_nxt, w_h_r, w_h_nxt;
  logic [ADDR_W-1:0] awa_r, awa_nxt;
  logic [31:0]       wd_r, wd_nxt;
  logic [3:0]        ws_r, ws_nxt;
  logic              awr_r, awr_nxt, wr_r, wr_nxt, arr_r, arr_nxt;
  logic              bv_r, bv_nxt, rv_r, rv_nxt;
  logic [1:0]        br_r, br_nxt, rr_r, rr_nxt;
  logic [31:0]       rd_r, rd_nxt;
  logic [2:0]        pin_r, pin_nxt;
  logic [7:0]        la_r, la_nxt, lw_r, lw_nxt, lrd_r, lrd_nxt;
  logic              lwr_r, lwr_nxt, lrr_r, lrr_nxt;

  // AXI slave plus the link sequencer that forwards one device access.
  always_comb
  begin
    st_nxt   = st_r;
    aw_h_nxt = aw_h_r | (s_axi_awvalid_i & awr_r);
    w_h_nxt  = w_h_r | (s_axi_wvalid_i & wr_r);
    awa_nxt  = (s_axi_awvalid_i & awr_r) ? s_axi_awaddr_i : awa_r;
    wd_nxt   = (s_axi_wvalid_i & wr_r) ? s_axi_wdata_i : wd_r;
    ws_nxt   = (s_axi_wvalid_i & wr_r) ? s_axi_wstrb_i : ws_r;
    bv_nxt   = bv_r & ~s_axi_bready_i;
    br_nxt   = br_r;
    rv_nxt   = rv_r & ~s_axi_rready_i;
    rr_nxt   = rr_r;
    rd_nxt   = rd_r;
    pin_nxt  = pin_r;
    la_nxt   = la_r;
    lw_nxt   = lw_r;
    lrd_nxt  = lrd_r;
    lwr_nxt  = 1'b0;
    lrr_nxt  = 1'b0;
    case (st_r)
      BRL_LINK_IDLE:
        st_nxt = BRL_LINK_IDLE;
      BRL_LINK_WAIT:
        if (bus.reg_ack)
        begin
          st_nxt  = BRL_LINK_IDLE;
          lrd_nxt = bus.reg_rdata;
        end
      default:
        st_nxt = BRL_LINK_IDLE;
    endcase
    if (aw_h_r & w_h_r & ~bv_r)
    begin
      aw_h_nxt = 1'b0;
      w_h_nxt  = 1'b0;
      bv_nxt   = 1'b1;
      br_nxt   = `BRL_RESP_OKAY;
      case (reg_sel(awa_r))
        2'h0:
          if (st_r == BRL_LINK_IDLE && ws_r[2:0] == 3'h7)
          begin
            la_nxt  = wd_r[7:0];
            lw_nxt  = wd_r[15:8];
            lrr_nxt = wd_r[16];
            lwr_nxt = ~wd_r[16];
            st_nxt  = BRL_LINK_WAIT;
          end
        2'h1:
          br_nxt = `BRL_RESP_OKAY;
        2'h2:
          if (ws_r[0])
            pin_nxt = wd_r[2:0];
        default:
          br_nxt = `BRL_RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid_i & arr_r)
    begin
      rv_nxt = 1'b1;
      rr_nxt = `BRL_RESP_OKAY;
      case (reg_sel(s_axi_araddr_i))
        2'h0:
          rd_nxt = {16'h0000, lw_r, la_r};
        2'h1:
          rd_nxt = {16'h0000, lrd_r, 7'h00, st_r == BRL_LINK_WAIT};
        2'h2:
          rd_nxt = {29'h00000000, pin_r};
        default:
        begin
          rd_nxt = 32'h00000000;
          rr_nxt = `BRL_RESP_SLVERR;
        end
      endcase
    end
    awr_nxt = ~aw_h_nxt & ~bv_nxt;
    wr_nxt  = ~w_h_nxt & ~bv_nxt;
    arr_nxt = ~rv_nxt;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_r   <= BRL_LINK_IDLE;
      aw_h_r <= 1'b0;
      w_h_r  <= 1'b0;
      awa_r  <= '0;
      wd_r   <= 32'h00000000;
      ws_r   <= 4'h0;
      awr_r  <= 1'b0;
      wr_r   <= 1'b0;
      arr_r  <= 1'b0;
      bv_r   <= 1'b0;
      br_r   <= 2'h0;
      rv_r   <= 1'b0;
      rr_r   <= 2'h0;
      rd_r   <= 32'h00000000;
      pin_r  <= 3'h0;
      la_r   <= 8'h00;
      lw_r   <= 8'h00;
      lrd_r  <= 8'h00;
      lwr_r  <= 1'b0;
      lrr_r  <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      aw_h_r <= aw_h_nxt;
      w_h_r  <= w_h_nxt;
      awa_r  <= awa_nxt;
      wd_r   <= wd_nxt;
      ws_r   <= ws_nxt;
      awr_r  <= awr_nxt;
      wr_r   <= wr_nxt;
      arr_r  <= arr_nxt;
      bv_r   <= bv_nxt;
      br_r   <= br_nxt;
      rv_r   <= rv_nxt;
      rr_r   <= rr_nxt;
      rd_r   <= rd_nxt;
      pin_r  <= pin_nxt;
      la_r   <= la_nxt;
      lw_r   <= lw_nxt;
      lrd_r  <= lrd_nxt;
      lwr_r  <= lwr_nxt;
      lrr_r  <= lrr_nxt;
    end
  end

  assign s_axi_awready_o = awr_r;
  assign s_axi_wready_o  = wr_r;
  assign s_axi_bvalid_o  = bv_r;
  assign s_axi_bresp_o   = br_r;
  assign s_axi_arready_o = arr_r;
  assign s_axi_rvalid_o  = rv_r;
  assign s_axi_rresp_o   = rr_r;
  assign s_axi_rdata_o   = rd_r;
  // Pin levels come from software; the device maps them to rails through its map registers.
  assign bus.level_pin   = pin_r;
  assign bus.reg_addr    = la_r;
  assign bus.reg_wdata   = lw_r;
  assign bus.reg_wr      = lwr_r;
  assign bus.reg_rd      = lrr_r;

endmodule : brl_host
`default_nettype wire

/* brl_link_checker.sv */
`include "brl_defs.svh"
`default_nettype none
module brl_link_checker
(
  input wire logic       clk_sys_i,
  input wire logic       rst_b_i,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_ack,
  input wire logic [2:0] level_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] mask_r;
  logic [4:0] mask_nxt;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  // Shadow of the first mask register, so read-back can be judged.
  always_comb
  begin
    mask_nxt = mask_r;
    if (reg_wr && reg_addr == `BRL_A_MASK_A)
      mask_nxt = reg_wdata[4:0];
  end

  // The shadow starts from the documented reset mask.
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      mask_r <= `BRL_MASK_A_RST;
    else
      mask_r <= mask_nxt;
  end

  sequence s_req;
    reg_wr || reg_rd;
  endsequence
  sequence s_ack;
    ##1 reg_ack ##1 !reg_ack;
  endsequence

  chk_req_gets_ack: assert property (s_req |-> s_ack)
    else $error("link request not answered by one ack pulse");
  chk_ack_has_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
    else $error("ack without a request");
  chk_one_request: assert property (!(reg_wr && reg_rd))
    else $error("read and write together");
  chk_req_spacing: assert property (s_req |=> !(reg_wr || reg_rd))
    else $error("requests closer than allowed");
  chk_rdata_source: assert property ($changed(reg_rdata) |-> reg_ack && $past(reg_rd))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_mask_readback: assert property (reg_rd && reg_addr == `BRL_A_MASK_A |=> reg_rdata == {3'h0, mask_r})
    else $error("mask read-back wrong");
  chk_status_spare: assert property (reg_rd && reg_addr == `BRL_A_STATUS |=> !reg_rdata[6])
    else $error("status spare bit set");
endmodule : brl_link_checker
`default_nettype wire

/* buck_rail_ok_and_level_select_tb_top.sv */
`include "brl_defs.svh"
`default_nettype none
module buck_rail_ok_and_level_select_tb_top;
  import brl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] d; logic [1:0] r;} brl_note_type;
  logic        clk_sys_i, rst_b_i, awv, wv, bready, arv, rready, conv, dual;
  logic        awr, wr_rdy, bvalid, arr, rvalid, rail_ok, probe;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, r;
  logic [1:0]  bresp, rresp, phase;
  logic [4:0]  win, cur, ramp;
  logic [39:0] codes;
  logic [59:0] mvs;
  int          pr_idx, fails, num_checks;
  brl_note_type note_q[$];
  brl_note_type n;
  localparam logic [9:0] CFG [6] = '{10'h3c8, 10'h008, 10'h00a, 10'h004,
                                     10'h018, 10'h009};
  localparam logic [35:0] LVL [6] = '{36'h0b002580b, 36'h0b8000000,
    36'h0b8521c05, 36'h7f006727f, 36'h830041083, 36'h83823fc82};

  brl_if link_if ();
  brl_host brl_host_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .bus(link_if), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready));
  brl_device brl_device_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .bus(link_if), .win_ok_i(win), .cur_ok_i(cur), .conv_cur_ok_i(conv),
    .dual_phase_i(dual), .rail_ok_o(rail_ok), .level_code_o(codes),
    .level_mv_o(mvs), .rail_ramping_o(ramp), .phase_mode_o(phase));
  brl_link_checker brl_link_checker_inst (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .reg_addr(link_if.reg_addr),
    .reg_wdata(link_if.reg_wdata), .reg_wr(link_if.reg_wr),
    .reg_rd(link_if.reg_rd), .reg_rdata(link_if.reg_rdata),
    .reg_ack(link_if.reg_ack), .level_pin(link_if.level_pin));

  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // Each write holds both channels until taken, then waits for the answer.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    note_q.push_back('{32'h0, er});
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    // One idle edge so a following call never re-raises bready at once.
    @(posedge clk_sys_i);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    note_q.push_back('{ed, er});
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (arr) arv <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    // One idle edge so a following call never re-raises rready at once.
    @(posedge clk_sys_i);
  endtask : axi_rd

  // The link finishes two cycles after the command's answer.
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
    axi_wr(`BRL_H_CMD, {16'h0, d, a}, `BRL_RESP_OKAY);
    repeat (3) @(posedge clk_sys_i);
  endtask : dev_wr

  task automatic dev_rd(input logic [7:0] a, input logic [7:0] e);
    axi_wr(`BRL_H_CMD, {15'h0, 1'b1, 8'h0, a}, `BRL_RESP_OKAY);
    repeat (3) @(posedge clk_sys_i);
    axi_rd(`BRL_H_STAT, {16'h0, e, 8'h0}, `BRL_RESP_OKAY);
  endtask : dev_rd

  task automatic chk_out(input int idx, input logic [22:0] e);
    note_q.push_back('{{9'h0, e}, 2'h0});
    pr_idx <= idx;
    probe <= 1'b1;
    @(posedge clk_sys_i);
    probe <= 1'b0;
  endtask : chk_out

  function automatic logic exp_ok(input logic [4:0] m, input logic [3:0] b,
                                  input logic d);
    logic [4:0] v;
    v = ((win | {5{b[0]}}) & cur) | m | {3'h0, d, 1'b0};
    return (&v & (conv | ~b[1] | b[2])) ^ b[3];
  endfunction : exp_ok

  // The monitor matches every answer or probe with the oldest note.
  always @(posedge clk_sys_i)
  begin
    if ((bvalid && bready) || (rvalid && rready) || probe)
    begin
      n = note_q.pop_front();
      if (bvalid && bready) check("bresp", {30'h0, bresp}, {30'h0, n.r});
      if (rvalid && rready) check("rdata", rdata, n.d);
      if (rvalid && rready) check("rresp", {30'h0, rresp}, {30'h0, n.r});
      if (probe) check("outputs", {9'h0, phase, rail_ok,
        mvs[12*pr_idx+:12], codes[8*pr_idx+:8]}, n.d);
    end
  end

  // Free-running system clock.
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // A hang is cut short well beyond the expected run length.
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    finish_test();
  end

  initial
  begin
    {rst_b_i, awv, wv, bready, arv, rready, probe, dual} = '0;
    {awaddr, araddr, wdata, pr_idx, fails, num_checks} = '0;
    win = 5'h1f;
    cur = 5'h1f;
    conv = 1'b1;
    r = $urandom(59056);
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    dev_rd(`BRL_A_MASK_A, 8'h1e);
    dev_rd(`BRL_A_MASK_B, 8'h04);
    dev_rd(8'h30, 8'h00);
    axi_rd(4'hc, 32'h0, `BRL_RESP_SLVERR);
    axi_wr(4'hc, 32'h1, `BRL_RESP_SLVERR);
    dev_wr(8'h30, 8'ha5);
    axi_rd(`BRL_H_CMD, 32'ha530, `BRL_RESP_OKAY);
    // Mask, type, converter, polarity and dual phase settings.
    for (int k = 0; k < 6; k++)
    begin
      dev_wr(`BRL_A_MASK_A, {3'h0, CFG[k][9:5]});
      dev_wr(`BRL_A_MASK_B, {4'h0, CFG[k][4:1]});
      dual <= CFG[k][0];
      for (int j = 0; j < 6; j++)
      begin
        r = $urandom;
        win <= r[4:0] | r[9:5] | r[14:10];
        cur <= r[19:15] | r[24:20] | r[29:25];
        conv <= r[30] | r[31];
        repeat (4) @(posedge clk_sys_i);
        chk_out(0, {2'h0, exp_ok(CFG[k][9:5], CFG[k][4:1], dual), 20'h0});
      end
    end
    dev_wr(`BRL_A_MASK_A, 8'h1e);
    dev_wr(`BRL_A_MASK_B, 8'h04);
    {dual, win, cur, conv} <= {1'b0, 5'h1f, 5'h1f, 1'b1};
    // Register choice and code decode on a stepping rail.
    for (int k = 0; k < 6; k++)
    begin
      dev_wr(`BRL_A_PRI_BASE + 8'h3, LVL[k][35:28]);
      dev_wr(`BRL_A_ALT_BASE + 8'h3, LVL[k][27:20]);
      repeat (2) @(posedge clk_sys_i);
      chk_out(3, {3'h1, LVL[k][19:0]});
    end
    dev_wr(`BRL_A_ALT_BASE + 8'h3, 8'h05);
    dev_wr(`BRL_A_CTL_BASE + 8'h3, 8'h01);
    dev_wr(`BRL_A_MAP_BASE + 8'h1, 8'h08);
    for (int p = 0; p < 4; p++)
    begin
      r = $urandom;
      axi_wr(`BRL_H_PINS, {29'h0, r[2], p[0], r[0]}, `BRL_RESP_OKAY);
      repeat (5) @(posedge clk_sys_i);
      chk_out(3, p[0] ? 23'h141083 : 23'h143885);
    end
    // A ramp hides the window result only while it runs.
    dev_wr(`BRL_A_PRI_BASE, 8'h01);
    dev_wr(`BRL_A_PRI_BASE, 8'h03);
    win <= 5'h1e;
    dev_rd(`BRL_A_STATUS, 8'h03);
    repeat (900) @(posedge clk_sys_i);
    chk_out(0, {3'h0, 12'd520, 8'h03});
    win <= 5'h1f;
    dual <= 1'b1;
    for (int v = 0; v < 3; v++)
    begin
      dev_wr(`BRL_A_PHASE, v[7:0]);
      repeat (2) @(posedge clk_sys_i);
      chk_out(0, {v[1:0], 1'b1, 12'd520, 8'h03});
    end
    finish_test();
  end
endmodule : buck_rail_ok_and_level_select_tb_top
`default_nettype wire
